/* hdl/sspc_core.sv */
// Synchronous serial port core: word FIFO and serial engine
// Operation
// - prescaler divides by even value 2..254
// - second divider by one plus rate field
// - master-only engine; sys clock at least 2x
// - 16-bit, 8-deep transmit FIFO from CPU
// - received words registered then pushed, CPU pops
// - four sources ORed into one request
// - mask 1 enables; raw and masked readable
// - frames of 4 to 16 bits, MSB first
// - clock idle, toggles only during frames
// - timeout when clock idle and data waiting
// - frame select low through SPI/half-duplex frame
// - pulsed format launches rising, samples falling
// - half-duplex: 8-bit control, wait, reply
// - pulsed idle: clock, frame low; data tristated
// - pulsed frame line high one period first
// - pulsed word pushed on next rising edge
// - SPI idle clock follows polarity bit
// - phase selects first or second capture edge
// - SPI idle: clock idle, select high, data low
// - phase 0: select low, half later data, then clock
// - select high one period after last capture
// - phase 0 pulses select between words
`timescale 1ns/100ps
`default_nettype none

module sspc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8,
    localparam int AW = $clog2(DEPTH)
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [AW:0] count
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    always_comb begin
        in_ready = cnt_q != (AW+1)'(DEPTH);
        out_valid = cnt_q != '0;
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        mem_d = mem_q;
        wp_d = wp_q;
        rp_d = rp_q;
        if (push) begin
            mem_d[wp_q] = in_data;
            wp_d = (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
        end
        if (pop) begin
            rp_d = (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
        end
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        out_data = mem_q[rp_q];
        count = cnt_q;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            mem_q <= mem_d;
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
    end
endmodule : sspc_fifo

module sspc_core #(
    parameter int FIFO_DEPTH = sspc_pkg::FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic port_enable,
    input wire logic slave_mode,
    input wire sspc_pkg::sspc_fmt_t frame_format,
    input wire logic clock_idle_polarity_bit,
    input wire logic capture_phase_bit,
    input wire logic [3:0] frame_size_minus1,
    input wire logic [7:0] prescale_divisor,
    input wire logic [7:0] serial_clock_rate_field,
    input wire logic [3:0] interrupt_mask_reg,
    input wire logic [3:0] irq_clear,
    output logic [3:0] raw_interrupt_status_reg,
    output logic [3:0] masked_interrupt_status_reg,
    output logic irq,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [sspc_pkg::DATA_W-1:0] tx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [sspc_pkg::DATA_W-1:0] rx_data,
    output logic serial_bit_clock,
    output logic serial_bit_clock_oe_n,
    output logic frame_select_line,
    output logic serial_out_line,
    output logic serial_out_oe_n,
    input wire logic serial_in_line
);
    localparam int CW = $clog2(FIFO_DEPTH) + 1;

    // ------------------------------------------------------------
    // Buffers
    // ------------------------------------------------------------
    logic tx_take, tx_out_valid, rx_push, rx_in_ready;
    logic [15:0] tx_out_data, rx_word;
    logic [CW-1:0] tx_cnt, rx_cnt;

    sspc_fifo #(.WIDTH(sspc_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .sys_clk(sys_clk), .rst_n(rst_n),
        .in_valid(tx_valid), .in_ready(tx_ready), .in_data(tx_data),
        .out_valid(tx_out_valid), .out_ready(tx_take), .out_data(tx_out_data),
        .count(tx_cnt)
    );
    sspc_fifo #(.WIDTH(sspc_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .sys_clk(sys_clk), .rst_n(rst_n),
        .in_valid(rx_push), .in_ready(rx_in_ready), .in_data(rx_word),
        .out_valid(rx_valid), .out_ready(rx_ready), .out_data(rx_data),
        .count(rx_cnt)
    );

    // ------------------------------------------------------------
    // Receive pin synchroniser
    // ------------------------------------------------------------
    // Three stages add latency: a pin change reaches capture 4 cycles late,
    // so a half bit period must be at least 5 system cycles
    logic [2:0] sync_q, sync_d;
    logic sin_q, sin_d;

    always_comb begin
        sync_d = {sync_q[1:0], serial_in_line};
        sin_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : sin_q;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_q <= 3'h0;
            sin_q <= 1'b0;
        end else begin
            sync_q <= sync_d;
            sin_q <= sin_d;
        end
    end

    // ------------------------------------------------------------
    // Bit rate divider: one tick per half bit period
    // ------------------------------------------------------------
    logic [6:0] pre_q, pre_d, pre_last;
    logic [7:0] scr_q, scr_d;
    logic tick, div_clr;

    always_comb begin
        // Odd or too small divisors would break the half-period split
        pre_last = (prescale_divisor < 8'(sspc_pkg::PRESCALE_MIN)) ? 7'h00
                 : 7'(prescale_divisor[7:1] - 7'h01);
        tick = (pre_q >= pre_last) && (scr_q >= serial_clock_rate_field);
        pre_d = (pre_q >= pre_last) ? 7'h00 : pre_q + 7'h01;
        scr_d = scr_q;
        if (pre_q >= pre_last) begin
            scr_d = tick ? 8'h00 : scr_q + 8'h01;
        end
        if (div_clr) begin
            pre_d = 7'h00;
            scr_d = 8'h00;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= 7'h00;
            scr_q <= 8'h00;
        end else begin
            pre_q <= pre_d;
            scr_q <= scr_d;
        end
    end

    // ------------------------------------------------------------
    // Serial engine
    // ------------------------------------------------------------
    function automatic logic is_capture(sspc_pkg::sspc_fmt_t f, logic ph, logic [5:0] e);
        logic r;
        r = 1'b0;
        unique case (f)
            sspc_pkg::SSPC_FMT_PULSED: r = !e[0] && e >= 6'h04;
            sspc_pkg::SSPC_FMT_SPI: r = e[0] ^ ph;
            default: r = e[0] && e >= 6'h13;
        endcase
        return r;
    endfunction : is_capture

    function automatic logic is_launch(sspc_pkg::sspc_fmt_t f, logic ph, logic [5:0] e,
                                       logic [5:0] last);
        logic r;
        r = 1'b0;
        unique case (f)
            sspc_pkg::SSPC_FMT_PULSED: r = e[0] && e >= 6'h03;
            sspc_pkg::SSPC_FMT_SPI: r = ph ? e[0] : (!e[0] && e < last);
            default: r = !e[0] && e <= 6'h10;
        endcase
        return r;
    endfunction : is_launch

    sspc_pkg::sspc_state_t st_q, st_d;
    sspc_pkg::sspc_fmt_t fmt_q, fmt_d;
    logic ph_q, ph_d, pol_q, pol_d, lvl_q, lvl_d, fss_q, fss_d, out_q, out_d;
    logic [4:0] n_q, n_d;
    logic [5:0] edge_q, edge_d, e, last_edge;
    logic [1:0] half_q, half_d;
    logic [15:0] sh_q, sh_d, rsh_q, rsh_d;
    logic more, load, ti_rise, hold_done, spi_ph1;
    logic [4:0] nsz;

    always_comb begin
        nsz = (frame_size_minus1 < 4'(sspc_pkg::FSIZE_MIN - 1)) ? 5'(sspc_pkg::FSIZE_MIN)
            : 5'(frame_size_minus1) + 5'h01;
        unique case (fmt_q)
            sspc_pkg::SSPC_FMT_PULSED: last_edge = {n_q, 1'b0} + 6'h02;
            sspc_pkg::SSPC_FMT_SPI: last_edge = {n_q, 1'b0};
            default: last_edge = {n_q, 1'b0} + 6'(2 * (sspc_pkg::HD_CTRL_BITS
                                                   + sspc_pkg::HD_WAIT_BITS));
        endcase
        spi_ph1 = fmt_q == sspc_pkg::SSPC_FMT_SPI && ph_q;
        hold_done = spi_ph1 ? half_q == 2'h1 : 1'b1;
        more = port_enable && !slave_mode && tx_out_valid;
        e = edge_q + 6'h01;
        st_d = st_q;
        fmt_d = fmt_q;
        ph_d = ph_q;
        pol_d = pol_q;
        n_d = n_q;
        lvl_d = lvl_q;
        fss_d = fss_q;
        out_d = out_q;
        edge_d = edge_q;
        half_d = half_q;
        sh_d = sh_q;
        rsh_d = rsh_q;
        load = 1'b0;
        ti_rise = 1'b0;
        rx_push = 1'b0;
        unique case (st_q)
            sspc_pkg::SSPC_ST_IDLE: begin
                lvl_d = 1'b0;
                out_d = 1'b0;
                fss_d = frame_format != sspc_pkg::SSPC_FMT_PULSED;
                if (more) begin
                    load = 1'b1;
                    // Pulsed format raises its frame pulse on the first edge instead
                    fss_d = 1'b0;
                    st_d = (frame_format == sspc_pkg::SSPC_FMT_PULSED) ? sspc_pkg::SSPC_ST_BITS
                         : sspc_pkg::SSPC_ST_SETUP;
                end
            end
            sspc_pkg::SSPC_ST_SETUP: begin
                if (tick) begin
                    // Phase 0 presents the MSB half a period before the first edge
                    if (!spi_ph1) begin
                        out_d = sh_q[15];
                        sh_d = {sh_q[14:0], 1'b0};
                    end
                    st_d = sspc_pkg::SSPC_ST_BITS;
                end
            end
            sspc_pkg::SSPC_ST_BITS: begin
                if (tick) begin
                    edge_d = e;
                    lvl_d = !lvl_q;
                    if (fmt_q == sspc_pkg::SSPC_FMT_PULSED) begin
                        if (e == 6'h01) begin
                            fss_d = 1'b1;
                        end
                        if (e == 6'h03) begin
                            fss_d = 1'b0;
                        end
                    end
                    if (is_launch(fmt_q, ph_q, e, last_edge)) begin
                        out_d = sh_q[15];
                        sh_d = {sh_q[14:0], 1'b0};
                    end
                    if (is_capture(fmt_q, ph_q, e)) begin
                        rsh_d = {rsh_q[14:0], sin_q};
                    end
                    if (e == last_edge) begin
                        half_d = 2'h0;
                        st_d = (fmt_q == sspc_pkg::SSPC_FMT_PULSED) ? sspc_pkg::SSPC_ST_END
                             : sspc_pkg::SSPC_ST_HOLD;
                    end
                end
            end
            sspc_pkg::SSPC_ST_HOLD: begin
                if (tick) begin
                    half_d = half_q + 2'h1;
                    if (hold_done) begin
                        rx_push = 1'b1;
                        if (spi_ph1 && more) begin
                            load = 1'b1;
                            st_d = sspc_pkg::SSPC_ST_SETUP;
                        end else begin
                            fss_d = 1'b1;
                            half_d = 2'h0;
                            st_d = more ? sspc_pkg::SSPC_ST_GAP : sspc_pkg::SSPC_ST_IDLE;
                        end
                    end
                end
            end
            sspc_pkg::SSPC_ST_GAP: begin
                if (tick) begin
                    half_d = half_q + 2'h1;
                    if (half_q == 2'h1) begin
                        if (more) begin
                            load = 1'b1;
                            fss_d = 1'b0;
                            st_d = sspc_pkg::SSPC_ST_SETUP;
                        end else begin
                            st_d = sspc_pkg::SSPC_ST_IDLE;
                        end
                    end
                end
            end
            sspc_pkg::SSPC_ST_END: begin
                if (tick) begin
                    rx_push = 1'b1;
                    if (more && frame_format == sspc_pkg::SSPC_FMT_PULSED) begin
                        load = 1'b1;
                        ti_rise = 1'b1;
                        st_d = sspc_pkg::SSPC_ST_BITS;
                    end else begin
                        st_d = sspc_pkg::SSPC_ST_IDLE;
                    end
                end
            end
            default: begin
                st_d = sspc_pkg::SSPC_ST_IDLE;
            end
        endcase
        if (load) begin
            fmt_d = frame_format;
            ph_d = capture_phase_bit;
            pol_d = clock_idle_polarity_bit;
            n_d = nsz;
            edge_d = 6'h00;
            half_d = 2'h0;
            rsh_d = 16'h0000;
            sh_d = (frame_format == sspc_pkg::SSPC_FMT_HALFDUP) ? {tx_out_data[7:0], 8'h00}
                 : 16'(tx_out_data << (5'd16 - nsz));
        end
        if (ti_rise) begin
            edge_d = 6'h01;
            lvl_d = 1'b1;
            fss_d = 1'b1;
        end
        tx_take = load;
        div_clr = load && st_q == sspc_pkg::SSPC_ST_IDLE;
        rx_word = rsh_q;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= sspc_pkg::SSPC_ST_IDLE;
            fmt_q <= sspc_pkg::SSPC_FMT_PULSED;
            ph_q <= 1'b0;
            pol_q <= 1'b0;
            n_q <= 5'(sspc_pkg::FSIZE_MIN);
            lvl_q <= 1'b0;
            fss_q <= 1'b1;
            out_q <= 1'b0;
            edge_q <= 6'h00;
            half_q <= 2'h0;
            sh_q <= 16'h0000;
            rsh_q <= 16'h0000;
        end else begin
            st_q <= st_d;
            fmt_q <= fmt_d;
            ph_q <= ph_d;
            pol_q <= pol_d;
            n_q <= n_d;
            lvl_q <= lvl_d;
            fss_q <= fss_d;
            out_q <= out_d;
            edge_q <= edge_d;
            half_q <= half_d;
            sh_q <= sh_d;
            rsh_q <= rsh_d;
        end
    end

    // ------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------
    logic idle;

    always_comb begin
        idle = st_q == sspc_pkg::SSPC_ST_IDLE;
        serial_bit_clock = lvl_q ^ (idle ? (frame_format == sspc_pkg::SSPC_FMT_SPI
                                            && clock_idle_polarity_bit)
                                         : (fmt_q == sspc_pkg::SSPC_FMT_SPI && pol_q));
        serial_bit_clock_oe_n = slave_mode;
        frame_select_line = fss_q;
        serial_out_line = out_q;
        serial_out_oe_n = idle && frame_format == sspc_pkg::SSPC_FMT_PULSED;
    end

    // ------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------
    logic [6:0] to_cnt_q, to_cnt_d;
    logic to_q, to_d, ov_q, ov_d, to_hit;
    logic [3:0] raw_q, raw_d, msk_q, msk_d;

    always_comb begin
        to_cnt_d = 7'h00;
        to_hit = 1'b0;
        if (idle && rx_valid) begin
            to_cnt_d = to_cnt_q;
            if (tick && to_cnt_q != 7'(sspc_pkg::TIMEOUT_HALVES)) begin
                to_cnt_d = to_cnt_q + 7'h01;
                to_hit = to_cnt_q == 7'(sspc_pkg::TIMEOUT_HALVES - 1);
            end
        end
        // A set in the cycle of its clear is kept
        to_d = to_hit || (to_q && !irq_clear[sspc_pkg::IRQ_TO]);
        ov_d = (rx_push && !rx_in_ready) || (ov_q && !irq_clear[sspc_pkg::IRQ_OV]);
        raw_d = {ov_d, to_d, rx_cnt >= CW'(sspc_pkg::SERVICE_LEVEL),
                 tx_cnt <= CW'(sspc_pkg::SERVICE_LEVEL)};
        msk_d = raw_d & interrupt_mask_reg;
        raw_interrupt_status_reg = raw_q;
        masked_interrupt_status_reg = msk_q;
        irq = |msk_q;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            to_cnt_q <= 7'h00;
            to_q <= 1'b0;
            ov_q <= 1'b0;
            raw_q <= sspc_pkg::IRQ_RST;
            msk_q <= sspc_pkg::IRQ_RST;
        end else begin
            to_cnt_q <= to_cnt_d;
            to_q <= to_d;
            ov_q <= ov_d;
            raw_q <= raw_d;
            msk_q <= msk_d;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_idle_clock;
        idle && $past(idle) |-> serial_bit_clock == (frame_format == sspc_pkg::SSPC_FMT_SPI
                                                   && clock_idle_polarity_bit);
    endproperty
    a_idle_clock: assert property (p_idle_clock) else $error("idle clock level wrong");
    property p_clock_on_tick;
        $changed(lvl_q) |-> $past(tick) && !$past(idle);
    endproperty
    a_clock_on_tick: assert property (p_clock_on_tick) else $error("clock moved off tick");
    property p_select_low;
        st_q == sspc_pkg::SSPC_ST_BITS && fmt_q != sspc_pkg::SSPC_FMT_PULSED
            |-> !frame_select_line;
    endproperty
    a_select_low: assert property (p_select_low) else $error("select high in frame");
    property p_pulsed_idle;
        idle && $past(idle) && $past(rst_n)
            && $past(frame_format) == sspc_pkg::SSPC_FMT_PULSED
            && frame_format == sspc_pkg::SSPC_FMT_PULSED
            |-> serial_out_oe_n && !frame_select_line && !serial_bit_clock;
    endproperty
    a_pulsed_idle: assert property (p_pulsed_idle) else $error("pulsed idle pins wrong");
    property p_overrun;
        rx_push && !rx_in_ready |=> raw_interrupt_status_reg[sspc_pkg::IRQ_OV];
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");
    property p_irq;
        irq == |(raw_interrupt_status_reg & $past(interrupt_mask_reg));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt line mismatch");
    property p_timeout;
        to_hit |=> raw_interrupt_status_reg[sspc_pkg::IRQ_TO];
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout not flagged");
    property p_select_return;
        st_q == sspc_pkg::SSPC_ST_HOLD && tick && hold_done && !(spi_ph1 && more)
            |=> frame_select_line;
    endproperty
    a_select_return: assert property (p_select_return) else $error("select not released");
    property p_pulse_start;
        st_q == sspc_pkg::SSPC_ST_BITS && fmt_q == sspc_pkg::SSPC_FMT_PULSED && tick
            && edge_q == 6'h00 |=> frame_select_line && serial_bit_clock;
    endproperty
    a_pulse_start: assert property (p_pulse_start) else $error("frame pulse missing");
    property p_frame_len;
        rx_push |-> edge_q == last_edge;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame length wrong");

    c_spi_end: cover property (rx_push && fmt_q == sspc_pkg::SSPC_FMT_SPI);
    c_pulsed_chain: cover property (ti_rise);
    c_halfdup: cover property (rx_push && fmt_q == sspc_pkg::SSPC_FMT_HALFDUP);
    c_overrun: cover property (rx_push && !rx_in_ready);
endmodule : sspc_core

`default_nettype wire

/* hdl/sspc_pkg.sv */
// Shared constants and types of the synchronous serial port core
package sspc_pkg;
    // ------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int FSIZE_MIN = 4;
    localparam int FSIZE_MAX = 16;
    localparam int HD_CTRL_BITS = 8;
    localparam int HD_WAIT_BITS = 1;
    // ------------------------------------------------------------
    // Bit rate
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20000000;
    localparam int PRESCALE_MIN = 2;
    localparam int PRESCALE_MAX = 254;
    // ------------------------------------------------------------
    // Status
    // ------------------------------------------------------------
    localparam int TIMEOUT_BIT_PERIODS = 32;
    localparam int TIMEOUT_HALVES = 2 * TIMEOUT_BIT_PERIODS;
    localparam int SERVICE_LEVEL = 4;
    localparam int IRQ_TX = 0;
    localparam int IRQ_RX = 1;
    localparam int IRQ_TO = 2;
    localparam int IRQ_OV = 3;
    localparam logic [3:0] IRQ_RST = 4'h0;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SSPC_FMT_PULSED = 2'b00,
        SSPC_FMT_SPI = 2'b01,
        SSPC_FMT_HALFDUP = 2'b10
    } sspc_fmt_t;
    typedef enum logic [2:0] {
        SSPC_ST_IDLE = 3'b000,
        SSPC_ST_SETUP = 3'b001,
        SSPC_ST_BITS = 3'b010,
        SSPC_ST_HOLD = 3'b011,
        SSPC_ST_GAP = 3'b100,
        SSPC_ST_END = 3'b101
    } sspc_state_t;
endpackage : sspc_pkg

/* test/sspc_slave_model.sv */
// Off-chip SPI slave model, mode 0, 8-bit replies
`timescale 1ns/100ps
`default_nettype none
module sspc_slave_model #(
    parameter logic [7:0] REPLY = 8'h5A
) (
    input wire logic sclk,
    input wire logic sel_n,
    input wire logic mosi,
    output logic miso,
    output logic [7:0] got,
    output int frames
);
    logic [7:0] sh;
    logic busy;
    initial begin
        miso = 1'b0;
        got = 8'h00;
        frames = 0;
        busy = 1'b0;
    end
    // Reply is presented as soon as select falls
    always @(negedge sel_n) begin
        sh = REPLY;
        miso = sh[7];
        busy = 1'b1;
    end
    always @(posedge sclk) if (!sel_n) got = {got[6:0], mosi};
    always @(negedge sclk) if (!sel_n) begin
        sh = sh << 1;
        miso = sh[7];
    end
    // Released line shows the inverse so stale data never passes
    always @(posedge sel_n) if (busy) begin
        miso = ~miso;
        frames = frames + 1;
        busy = 1'b0;
    end
endmodule : sspc_slave_model
`default_nettype wire

/* test/tb_sspc_core.sv */
// Bench for the serial port core: SPI mode 0 master traffic
`timescale 1ns/100ps
`default_nettype none
module tb_sspc_core;
    logic sys_clk, rst_n, en, slv, pol, pha, tx_valid, tx_ready, rx_valid, rx_ready;
    logic sclk, sclk_oe_n, sel_n, mosi, mosi_oe_n, miso, irq;
    logic [3:0] fsz, mask, clr, raw, msk;
    logic [7:0] psc, rate, got;
    logic [15:0] tx_data, rx_data;
    sspc_pkg::sspc_fmt_t fmt;
    int frames, mismatches, total_checks;
    sspc_core sspc_core_i (.sys_clk(sys_clk), .rst_n(rst_n), .port_enable(en),
        .slave_mode(slv), .frame_format(fmt), .clock_idle_polarity_bit(pol),
        .capture_phase_bit(pha), .frame_size_minus1(fsz), .prescale_divisor(psc),
        .serial_clock_rate_field(rate), .interrupt_mask_reg(mask), .irq_clear(clr),
        .raw_interrupt_status_reg(raw), .masked_interrupt_status_reg(msk), .irq(irq),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_data(rx_data), .serial_bit_clock(sclk),
        .serial_bit_clock_oe_n(sclk_oe_n), .frame_select_line(sel_n),
        .serial_out_line(mosi), .serial_out_oe_n(mosi_oe_n), .serial_in_line(miso));
    sspc_slave_model sspc_slave_model_i (.sclk(sclk), .sel_n(sel_n), .mosi(mosi),
        .miso(miso), .got(got), .frames(frames));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        #1000000;
        mismatches++;
        end_of_test();
    end
    initial begin
        {rst_n, en, slv, pol, pha, tx_valid, rx_ready} = 7'h00;
        {mask, clr, tx_data} = 24'h000000;
        fmt = sspc_pkg::SSPC_FMT_SPI;
        fsz = 4'h7;
        // Half-bit tick of 6 cycles covers the four-cycle receive path
        psc = 8'h0C;
        rate = 8'h00;
        mismatches = 0;
        total_checks = 0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(negedge sys_clk);
        chk("idle pins", 16'h0440, {sclk, sel_n, sclk_oe_n, mosi, mosi_oe_n, tx_ready, rx_valid, irq, raw});
        $display("reset test done");
        @(posedge sys_clk);
        tx_valid <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            tx_data <= 16'hC300 | 16'(i);
            @(posedge sys_clk);
        end
        chk("full refuses", 16'h0000, {15'h0000, tx_ready});
        tx_valid <= 1'b0;
        en <= 1'b1;
        mask <= 4'hA;
        for (int i = 0; i < 3000 && frames < 8; i++) @(posedge sys_clk);
        repeat (4) @(posedge sys_clk);
        chk("frames", 16'h0008, 16'(frames));
        chk("last word out", 16'h0007, {8'h00, got});
        chk("irq status", 16'h0012, {11'h000, irq, msk});
        $display("transmit test done");
        tx_data <= 16'h00F0;
        tx_valid <= 1'b1;
        @(posedge sys_clk);
        tx_valid <= 1'b0;
        for (int i = 0; i < 2000 && raw[sspc_pkg::IRQ_OV] !== 1'b1; i++) @(posedge sys_clk);
        chk("overrun", 16'h0001, {15'h0000, raw[sspc_pkg::IRQ_OV]});
        chk("ninth word out", 16'h00F0, {8'h00, got});
        for (int i = 0; i < 1000 && raw[sspc_pkg::IRQ_TO] !== 1'b1; i++) @(posedge sys_clk);
        chk("timeout", 16'h0001, {15'h0000, raw[sspc_pkg::IRQ_TO]});
        $display("status test done");
        rx_ready <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(negedge sys_clk);
            chk("rx word", 16'h015A, {7'h00, rx_valid, rx_data[7:0]});
            @(posedge sys_clk);
        end
        rx_ready <= 1'b0;
        clr <= 4'hC;
        @(posedge sys_clk);
        clr <= 4'h0;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("after clear", 16'h0001, {10'h000, rx_valid, irq, raw});
        $display("receive test done");
        end_of_test();
    end
endmodule : tb_sspc_core
`default_nettype wire
